// ==== rtl/imptu_map.vh ====
`ifndef IMPTU_MAP_VH
`define IMPTU_MAP_VH

// register byte addresses
`define IMPTU_ADDR_MASK0     32'hFFFF_F100
`define IMPTU_ADDR_MASK1     32'hFFFF_F104
`define IMPTU_ADDR_MASK2     32'hFFFF_F108
`define IMPTU_ADDR_ISL       32'hFFFF_F10C
`define IMPTU_ADDR_PSW       32'hFFFF_F110
`define IMPTU_ADDR_EXC_PC    32'hFFFF_F114
`define IMPTU_ADDR_EXC_PSW   32'hFFFF_F118
`define IMPTU_ADDR_EXC_CAUSE 32'hFFFF_F11C
`define IMPTU_ADDR_WDT       32'hFFFF_F6D0

// reset values
`define IMPTU_MASK_RST       16'hFFFF
`define IMPTU_ISL_RST        8'h00
`define IMPTU_PSW_RST        32'h0000_0020
`define IMPTU_WDT_RST        8'h67
`define IMPTU_WDT_MODE_RST   2'h3

// status word fields
`define IMPTU_PSW_ID         5
`define IMPTU_PSW_EP         6
`define IMPTU_PSW_NP         7

// watchdog mode field
`define IMPTU_WDT_HI         6
`define IMPTU_WDT_LO         5

// trap vectors and cause
`define IMPTU_VEC_LOW        32'h0000_0040
`define IMPTU_VEC_HIGH       32'h0000_0050
`define IMPTU_VEC_SPLIT      4
`define IMPTU_CAUSE_TRAP     16'h0040

// axi responses
`define IMPTU_RESP_OKAY      2'h0
`define IMPTU_RESP_SLVERR    2'h2

`endif

// ==== rtl/imptu_top.v ====
// Overview of operation
// - mask group bits and per-source mask bits share one storage
// - mask groups take 16-bit access, bytes separately by strobes
// - reset loads every mask group with all ones
// - maskable acknowledge sets in-service bit of its priority level
// - return clears only the highest-priority set in-service bit
// - in-service bits untouched on return from nonmaskable or exception
// - in-service register read-only, resets to zero
// - status bit 5 blocks maskable acknowledge when one
// - disable sets, enable clears, return and load update block flag
// - nonmaskable and exceptions ignore block flag; maskable ack sets it
// - status word resets with only block flag set
// - watchdog mode register resets 67h, byte wide, two-bit mode field
// - software trap always raises an accepted exception
// - trap entry saves return pc and status word
// - trap entry writes cause low half, keeps upper half
// - trap entry sets exception-active and block flags
// - vector 00h-0Fh goes to 40h, 10h-1Fh to 50h
// - return with exception-active restores pc and status from saves
// - status bit 6 is the exception-active flag, set on exception
`include "imptu_map.vh"
`default_nettype none

module imptu_top #(
	parameter NUM_SRC = 43,
	parameter LVL_W   = 3,
	parameter SRC_W   = 6
) (
	input  wire                 CLK_IN,
	input  wire                 ARST_N_IN,
	input  wire [31:0]          AXI_AWADDR_IN,
	input  wire                 AXI_AWVALID_IN,
	output reg                  AXI_AWREADY_OUT,
	input  wire [31:0]          AXI_WDATA_IN,
	input  wire [3:0]           AXI_WSTRB_IN,
	input  wire                 AXI_WVALID_IN,
	output reg                  AXI_WREADY_OUT,
	output reg  [1:0]           AXI_BRESP_OUT,
	output reg                  AXI_BVALID_OUT,
	input  wire                 AXI_BREADY_IN,
	input  wire [31:0]          AXI_ARADDR_IN,
	input  wire                 AXI_ARVALID_IN,
	output reg                  AXI_ARREADY_OUT,
	output reg  [31:0]          AXI_RDATA_OUT,
	output reg  [1:0]           AXI_RRESP_OUT,
	output reg                  AXI_RVALID_OUT,
	input  wire                 AXI_RREADY_IN,
	input  wire                 SRC_MASK_WR_IN,
	input  wire [SRC_W-1:0]     SRC_MASK_IDX_IN,
	input  wire                 SRC_MASK_VAL_IN,
	input  wire                 MI_REQ_IN,
	input  wire [SRC_W-1:0]     MI_REQ_SRC_IN,
	input  wire [LVL_W-1:0]     MI_REQ_LVL_IN,
	input  wire                 INTR_OFF_IN,
	input  wire                 INTR_ON_IN,
	input  wire                 SYSREG_LD_IN,
	input  wire [31:0]          SYSREG_DATA_IN,
	input  wire                 RETURN_FROM_INTR_INSTRUCTION_IN,
	input  wire [31:0]          RETURN_FROM_INTR_INSTRUCTION_PSW_IN,
	input  wire                 TRAP_IN,
	input  wire [4:0]           TRAP_VEC_IN,
	input  wire [31:0]          TRAP_PC_IN,
	output reg                  MI_ACK_OUT,
	output reg                  PC_LOAD_OUT,
	output reg  [31:0]          PC_VALUE_OUT,
	output reg  [31:0]          PSW_OUT,
	output reg  [(1<<LVL_W)-1:0] ISL_OUT,
	output reg  [NUM_SRC-1:0]   MASK_OUT,
	output reg  [1:0]           WDT_MODE_OUT
);

	localparam NLVL   = 1 << LVL_W;
	localparam MASK_W = 48;

	reg  [MASK_W-1:0] mask_reg, mask_next;
	reg  [NLVL-1:0]   isl_reg, isl_next;
	reg  [31:0]       psw_reg, psw_next;
	reg  [31:0]       epc_reg, epc_next;
	reg  [31:0]       epsw_reg, epsw_next;
	reg  [31:0]       cause_reg, cause_next;
	reg  [7:0]        wdt_reg, wdt_next;
	reg               ack_next;
	reg               pcld_next;
	reg  [31:0]       pcval_next;

	reg               aw_full_reg;
	reg  [31:0]       aw_addr_reg;
	reg               w_full_reg;
	reg  [31:0]       w_data_reg;
	reg  [3:0]        w_strb_reg;
	reg  [31:0]       rd_mux;
	reg               rd_hit;
	reg               wr_hit;
	reg               lvl_free;
	reg               clr_done;
	reg  [MASK_W-1:0] mask_rd;
	reg  [31:0]       mask_wr;
	integer           i;

	wire aw_fire = AXI_AWVALID_IN & AXI_AWREADY_OUT;
	wire w_fire  = AXI_WVALID_IN & AXI_WREADY_OUT;
	wire ar_fire = AXI_ARVALID_IN & AXI_ARREADY_OUT;
	// a new write waits until the previous response has been taken
	wire do_wr   = aw_full_reg & w_full_reg & ~AXI_BVALID_OUT;
	wire aw_full_next = (aw_full_reg | aw_fire) & ~do_wr;
	wire w_full_next  = (w_full_reg | w_fire) & ~do_wr;
	wire bvalid_next  = do_wr | (AXI_BVALID_OUT & ~AXI_BREADY_IN);
	wire rvalid_next  = ar_fire | (AXI_RVALID_OUT & ~AXI_RREADY_IN);

	// byte lane merge for writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[k*8 +: 8] = data[k*8 +: 8];
		end
	endfunction

	// unassigned mask bits read as one; their stored bits are written but never read
	always @*
	begin
		mask_rd = mask_reg;
		for (i = NUM_SRC; i < MASK_W; i = i + 1)
			mask_rd[i] = 1'b1;
	end

	// read decode
	always @*
	begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (AXI_ARADDR_IN)
			`IMPTU_ADDR_MASK0:     rd_mux[15:0] = mask_rd[15:0];
			`IMPTU_ADDR_MASK1:     rd_mux[15:0] = mask_rd[31:16];
			`IMPTU_ADDR_MASK2:     rd_mux[15:0] = mask_rd[47:32];
			`IMPTU_ADDR_ISL:       rd_mux[NLVL-1:0] = isl_reg;
			`IMPTU_ADDR_PSW:       rd_mux = psw_reg;
			`IMPTU_ADDR_EXC_PC:    rd_mux = epc_reg;
			`IMPTU_ADDR_EXC_PSW:   rd_mux = epsw_reg;
			`IMPTU_ADDR_EXC_CAUSE: rd_mux = cause_reg;
			`IMPTU_ADDR_WDT:       rd_mux[7:0] = wdt_reg;
			default:               rd_hit = 1'b0;
		endcase
	end

	// next-state logic; one cpu event per cycle is assumed, trap first
	always @*
	begin
		mask_next  = mask_reg;
		isl_next   = isl_reg;
		psw_next   = psw_reg;
		epc_next   = epc_reg;
		epsw_next  = epsw_reg;
		cause_next = cause_reg;
		wdt_next   = wdt_reg;
		ack_next   = 1'b0;
		pcld_next  = 1'b0;
		pcval_next = PC_VALUE_OUT;
		wr_hit     = 1'b1;
		lvl_free   = 1'b1;
		clr_done   = 1'b0;
		mask_wr    = 32'h0000_0000;

		if (do_wr)
		begin
			case (aw_addr_reg)
				// byte lanes per half
				// upper lanes are masked off, so only the low half is kept
				`IMPTU_ADDR_MASK0:
				begin
					mask_wr = merge({16'h0000, mask_reg[15:0]},
						w_data_reg, w_strb_reg & 4'h3);
					mask_next[15:0] = mask_wr[15:0];
				end
				`IMPTU_ADDR_MASK1:
				begin
					mask_wr = merge({16'h0000, mask_reg[31:16]},
						w_data_reg, w_strb_reg & 4'h3);
					mask_next[31:16] = mask_wr[15:0];
				end
				`IMPTU_ADDR_MASK2:
				begin
					mask_wr = merge({16'h0000, mask_reg[47:32]},
						w_data_reg, w_strb_reg & 4'h3);
					mask_next[47:32] = mask_wr[15:0];
				end
				`IMPTU_ADDR_ISL:       wr_hit = 1'b1;
				`IMPTU_ADDR_PSW:
					psw_next = merge(psw_reg, w_data_reg, w_strb_reg);
				`IMPTU_ADDR_EXC_PC:
					epc_next = merge(epc_reg, w_data_reg, w_strb_reg);
				`IMPTU_ADDR_EXC_PSW:
					epsw_next = merge(epsw_reg, w_data_reg, w_strb_reg);
				`IMPTU_ADDR_EXC_CAUSE:
					cause_next = merge(cause_reg, w_data_reg, w_strb_reg);
				`IMPTU_ADDR_WDT:
					if (w_strb_reg[0])
						wdt_next = w_data_reg[7:0];
				default:               wr_hit = 1'b0;
			endcase
		end

		// per-source path writes the same bits
		if (SRC_MASK_WR_IN && (SRC_MASK_IDX_IN < NUM_SRC))
			mask_next[SRC_MASK_IDX_IN] = SRC_MASK_VAL_IN;

		// nesting needs strictly higher priority than every level in service
		for (i = 0; i < NLVL; i = i + 1)
			if (isl_reg[i] && (i <= MI_REQ_LVL_IN))
				lvl_free = 1'b0;

		if (TRAP_IN)
		begin
			epc_next  = TRAP_PC_IN;
			epsw_next = psw_reg;
			cause_next[15:0] = `IMPTU_CAUSE_TRAP | {11'h000, TRAP_VEC_IN};
			psw_next = psw_reg;
			psw_next[`IMPTU_PSW_EP] = 1'b1;
			psw_next[`IMPTU_PSW_ID] = 1'b1;
			pcld_next = 1'b1;
			pcval_next = TRAP_VEC_IN[`IMPTU_VEC_SPLIT] ? `IMPTU_VEC_HIGH
				: `IMPTU_VEC_LOW;
		end
		else if (RETURN_FROM_INTR_INSTRUCTION_IN)
		begin
			if (psw_reg[`IMPTU_PSW_EP])
			begin
				psw_next   = epsw_reg;
				pcld_next  = 1'b1;
				pcval_next = epc_reg;
			end
			else
			begin
				psw_next = RETURN_FROM_INTR_INSTRUCTION_PSW_IN;
				if (!psw_reg[`IMPTU_PSW_NP])
				begin
					for (i = 0; i < NLVL; i = i + 1)
						if (isl_reg[i] && !clr_done)
						begin
							isl_next[i] = 1'b0;
							clr_done = 1'b1;
						end
				end
			end
		end
		else if (SYSREG_LD_IN)
			psw_next = SYSREG_DATA_IN;
		else if (INTR_OFF_IN)
			psw_next[`IMPTU_PSW_ID] = 1'b1;
		else if (INTR_ON_IN)
			psw_next[`IMPTU_PSW_ID] = 1'b0;
		else if (MI_REQ_IN && !psw_reg[`IMPTU_PSW_ID] && lvl_free
			&& (MI_REQ_SRC_IN < NUM_SRC) && !mask_reg[MI_REQ_SRC_IN])
		begin
			ack_next = 1'b1;
			isl_next[MI_REQ_LVL_IN] = 1'b1;
			psw_next[`IMPTU_PSW_ID] = 1'b1;
		end
	end

	// bus handshake and response state
	always @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			aw_full_reg     <= 1'b0;
			aw_addr_reg     <= 32'h0000_0000;
			w_full_reg      <= 1'b0;
			w_data_reg      <= 32'h0000_0000;
			w_strb_reg      <= 4'h0;
			AXI_AWREADY_OUT <= 1'b0;
			AXI_WREADY_OUT  <= 1'b0;
			AXI_BVALID_OUT  <= 1'b0;
			AXI_BRESP_OUT   <= `IMPTU_RESP_OKAY;
			AXI_ARREADY_OUT <= 1'b0;
			AXI_RVALID_OUT  <= 1'b0;
			AXI_RDATA_OUT   <= 32'h0000_0000;
			AXI_RRESP_OUT   <= `IMPTU_RESP_OKAY;
		end
		else
		begin
			aw_full_reg     <= aw_full_next;
			w_full_reg      <= w_full_next;
			AXI_AWREADY_OUT <= ~aw_full_next;
			AXI_WREADY_OUT  <= ~w_full_next;
			AXI_BVALID_OUT  <= bvalid_next;
			AXI_ARREADY_OUT <= ~rvalid_next;
			AXI_RVALID_OUT  <= rvalid_next;
			if (aw_fire)
				aw_addr_reg <= AXI_AWADDR_IN;
			if (w_fire)
			begin
				w_data_reg <= AXI_WDATA_IN;
				w_strb_reg <= AXI_WSTRB_IN;
			end
			if (do_wr)
				AXI_BRESP_OUT <= wr_hit ? `IMPTU_RESP_OKAY : `IMPTU_RESP_SLVERR;
			if (ar_fire)
			begin
				AXI_RDATA_OUT <= rd_mux;
				AXI_RRESP_OUT <= rd_hit ? `IMPTU_RESP_OKAY : `IMPTU_RESP_SLVERR;
			end
		end
	end

	// control state
	always @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			mask_reg     <= {3{`IMPTU_MASK_RST}};
			isl_reg      <= `IMPTU_ISL_RST;
			psw_reg      <= `IMPTU_PSW_RST;
			epc_reg      <= 32'h0000_0000;
			epsw_reg     <= 32'h0000_0000;
			cause_reg    <= 32'h0000_0000;
			wdt_reg      <= `IMPTU_WDT_RST;
			MI_ACK_OUT   <= 1'b0;
			PC_LOAD_OUT  <= 1'b0;
			PC_VALUE_OUT <= 32'h0000_0000;
			PSW_OUT      <= `IMPTU_PSW_RST;
			ISL_OUT      <= `IMPTU_ISL_RST;
			MASK_OUT     <= {NUM_SRC{1'b1}};
			WDT_MODE_OUT <= `IMPTU_WDT_MODE_RST;
		end
		else
		begin
			mask_reg     <= mask_next;
			isl_reg      <= isl_next;
			psw_reg      <= psw_next;
			epc_reg      <= epc_next;
			epsw_reg     <= epsw_next;
			cause_reg    <= cause_next;
			wdt_reg      <= wdt_next;
			MI_ACK_OUT   <= ack_next;
			PC_LOAD_OUT  <= pcld_next;
			PC_VALUE_OUT <= pcval_next;
			PSW_OUT      <= psw_next;
			ISL_OUT      <= isl_next;
			MASK_OUT     <= mask_next[NUM_SRC-1:0];
			WDT_MODE_OUT <= {wdt_next[`IMPTU_WDT_HI], wdt_next[`IMPTU_WDT_LO]};
		end
	end

endmodule // imptu_top

`default_nettype wire

// ==== sim/imptu_monitor.sv ====
`default_nettype none
module imptu_monitor #(
	parameter NUM_SRC = 43,
	parameter LVL_W   = 3,
	parameter SRC_W   = 6
) (
	input wire                    CLK_IN,
	input wire                    ARST_N_IN,
	input wire                    MI_REQ_IN,
	input wire [SRC_W-1:0]        MI_REQ_SRC_IN,
	input wire [LVL_W-1:0]        MI_REQ_LVL_IN,
	input wire                    INTR_OFF_IN,
	input wire                    SYSREG_LD_IN,
	input wire                    RETURN_FROM_INTR_INSTRUCTION_IN,
	input wire                    TRAP_IN,
	input wire [4:0]              TRAP_VEC_IN,
	input wire                    MI_ACK_OUT,
	input wire                    PC_LOAD_OUT,
	input wire [31:0]             PC_VALUE_OUT,
	input wire [31:0]             PSW_OUT,
	input wire [(1<<LVL_W)-1:0]   ISL_OUT,
	input wire [NUM_SRC-1:0]      MASK_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	wire                    vec_hi   = TRAP_VEC_IN[4];
	wire                    return_from_intr_instruction_now = RETURN_FROM_INTR_INSTRUCTION_IN && !TRAP_IN;
	// lowest set index is the highest priority level
	wire [(1<<LVL_W)-1:0]   isl_drop = ISL_OUT & (ISL_OUT - 1'b1);
	a_trap_vector:
	assert property (TRAP_IN |=> PC_LOAD_OUT &&
		PC_VALUE_OUT == ($past(vec_hi) ? 32'h0000_0050 : 32'h0000_0040))
		else $error("trap handler address wrong");
	a_trap_flags:
	assert property (TRAP_IN |=> PSW_OUT[6] && PSW_OUT[5]) else $error("trap flags not set");
	a_ack_level:
	assert property (MI_ACK_OUT |-> ISL_OUT[$past(MI_REQ_LVL_IN)]) else $error("level bit not set");
	a_ack_blocks:
	assert property (MI_ACK_OUT |-> PSW_OUT[5]) else $error("ack left block flag clear");
	a_block_holds:
	assert property (PSW_OUT[5] |=> !MI_ACK_OUT) else $error("ack while blocked");
	a_mask_holds:
	assert property (MI_REQ_IN && MI_REQ_SRC_IN < NUM_SRC && MASK_OUT[MI_REQ_SRC_IN] |=> !MI_ACK_OUT)
		else $error("ack of masked source");
	a_off_sets:
	assert property (INTR_OFF_IN && !return_from_intr_instruction_now && !TRAP_IN && !SYSREG_LD_IN |=> PSW_OUT[5])
		else $error("disable left flag clear");
	a_isl_lowest:
	assert property (return_from_intr_instruction_now && !PSW_OUT[6] && !PSW_OUT[7] |=> ISL_OUT == $past(isl_drop))
		else $error("return cleared wrong level");
	a_exc_return:
	assert property (return_from_intr_instruction_now && PSW_OUT[6] |=> PC_LOAD_OUT && $stable(ISL_OUT))
		else $error("exception return wrong");
	c_ack: cover property (MI_ACK_OUT);
	c_trap: cover property (TRAP_IN ##1 PC_LOAD_OUT);
	c_exc_ret: cover property (return_from_intr_instruction_now && PSW_OUT[6]);
endmodule // imptu_monitor
bind imptu_top imptu_monitor #(.NUM_SRC(NUM_SRC), .LVL_W(LVL_W), .SRC_W(SRC_W)) mon_u (
	.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .MI_REQ_IN(MI_REQ_IN),
	.MI_REQ_SRC_IN(MI_REQ_SRC_IN), .MI_REQ_LVL_IN(MI_REQ_LVL_IN), .INTR_OFF_IN(INTR_OFF_IN),
	.SYSREG_LD_IN(SYSREG_LD_IN), .RETURN_FROM_INTR_INSTRUCTION_IN(RETURN_FROM_INTR_INSTRUCTION_IN), .TRAP_IN(TRAP_IN),
	.TRAP_VEC_IN(TRAP_VEC_IN), .MI_ACK_OUT(MI_ACK_OUT), .PC_LOAD_OUT(PC_LOAD_OUT),
	.PC_VALUE_OUT(PC_VALUE_OUT), .PSW_OUT(PSW_OUT), .ISL_OUT(ISL_OUT), .MASK_OUT(MASK_OUT));
`default_nettype wire

// ==== sim/imptu_src_model.sv ====
`default_nettype none
module imptu_src_model (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        start_in,
	input  wire logic [5:0]  src_in,
	input  wire logic [2:0]  lvl_in,
	input  wire logic        ack_in,
	output logic             req_out,
	output logic [5:0]       src_out,
	output logic [2:0]       lvl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] age_reg;
	// blocked requests give up after a few cycles; released lines invert
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			req_out <= 1'b0;
			src_out <= 6'h3F;
			lvl_out <= 3'h7;
			age_reg <= 3'h0;
		end
		else if (start_in)
		begin
			req_out <= 1'b1;
			src_out <= src_in;
			lvl_out <= lvl_in;
			age_reg <= 3'h0;
		end
		else if (req_out && (ack_in || age_reg == 3'h4))
		begin
			req_out <= 1'b0;
			src_out <= ~src_out;
			lvl_out <= ~lvl_out;
		end
		else
			age_reg <= age_reg + 3'h1;
	end
endmodule // imptu_src_model
`default_nettype wire

// ==== sim/imptu_tb_top.sv ====
`include "imptu_map.vh"
`default_nettype none
module imptu_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, arst_n, awv, wv, bready, arv, rready, mwr, mval, start;
	logic [31:0] awaddr, wdata, araddr, sdata, rpsw, tpc, d;
	logic [3:0]  wstrb;
	logic [4:0]  ev, tvec;
	logic [5:0]  midx, ssrc;
	logic [2:0]  slvl;
	logic [1:0]  rs, bs;
	wire         awready, wready, bvalid, arready, rvalid, req, ack, pcl;
	wire [1:0]   bresp, rresp, wdm;
	wire [31:0]  rdata, pcv, program_status_word;
	wire [5:0]   rsrc;
	wire [2:0]   rlvl;
	wire [7:0]   isl;
	wire [42:0]  mask;
	int          miscompares, samples_checked, acks, cyc;
	imptu_top dut_u (.CLK_IN(clk), .ARST_N_IN(arst_n), .AXI_AWADDR_IN(awaddr),
		.AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata),
		.AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wready),
		.AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arready),
		.AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
		.AXI_RREADY_IN(rready), .SRC_MASK_WR_IN(mwr), .SRC_MASK_IDX_IN(midx),
		.SRC_MASK_VAL_IN(mval), .MI_REQ_IN(req), .MI_REQ_SRC_IN(rsrc), .MI_REQ_LVL_IN(rlvl),
		.INTR_OFF_IN(ev[0]), .INTR_ON_IN(ev[1]), .SYSREG_LD_IN(ev[2]),
		.SYSREG_DATA_IN(sdata), .RETURN_FROM_INTR_INSTRUCTION_IN(ev[3]), .RETURN_FROM_INTR_INSTRUCTION_PSW_IN(rpsw), .TRAP_IN(ev[4]),
		.TRAP_VEC_IN(tvec), .TRAP_PC_IN(tpc), .MI_ACK_OUT(ack), .PC_LOAD_OUT(pcl),
		.PC_VALUE_OUT(pcv), .PSW_OUT(program_status_word), .ISL_OUT(isl), .MASK_OUT(mask), .WDT_MODE_OUT(wdm));
	imptu_src_model src_u (.clk_in(clk), .rst_n_in(arst_n), .start_in(start), .src_in(ssrc),
		.lvl_in(slvl), .ack_in(ack), .req_out(req), .src_out(rsrc), .lvl_out(rlvl));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// sampled mid-cycle so the one-cycle pulse is seen exactly once
	always @(negedge clk) if (ack === 1'b1) acks++;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	// ready sampled at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
		logic r1, r2, b;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		{awv, wv, bready} <= 3'b111;
		b = 1'b0;
		while (!b)
		begin
			@(negedge clk);
			r1 = awready;
			r2 = wready;
			b = bvalid;
			bs = bresp;
			@(posedge clk);
			if (r1) awv <= 1'b0;
			if (r2) wv <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		logic r, v;
		@(posedge clk);
		araddr <= a;
		{arv, rready} <= 2'b11;
		v = 1'b0;
		while (!v)
		begin
			@(negedge clk);
			r = arready;
			v = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge clk);
			if (r) arv <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 5'h00;
		#1;
	endtask
	task automatic mreq(input logic [5:0] s, input logic [2:0] l);
		@(posedge clk);
		{start, ssrc, slvl} <= {1'b1, s, l};
		@(posedge clk);
		start <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		{arst_n, awv, wv, bready, arv, rready, mwr, mval, start} = '0;
		{awaddr, wdata, araddr, sdata, rpsw, tpc, wstrb, ev, tvec, midx, ssrc, slvl} = '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		chk("mask_out", 32'hFFFF_FFFF, mask[31:0]);
		chk("wdt_mode", 32'h0000_0003, wdm);
		for (int i = 0; i < 3; i++) rc("mask_grp", `IMPTU_ADDR_MASK0 + 4 * i, 32'h0000_FFFF);
		rc("psw", `IMPTU_ADDR_PSW, 32'h0000_0020);
		rc("wdt", `IMPTU_ADDR_WDT, 32'h0000_0067);
		rd(32'hFFFF_F200);
		chk("unmapped_resp", 32'h0000_0002, rs);
		wr(`IMPTU_ADDR_ISL, 32'h0000_00FF, 4'hF);
		chk("isl_wr_resp", 32'h0000_0000, bs);
		wr(32'hFFFF_F200, 32'h0000_0000, 4'hF);
		chk("unmapped_wr_resp", 32'h0000_0002, bs);
		rc("isl", `IMPTU_ADDR_ISL, 32'h0000_0000);
		wr(`IMPTU_ADDR_MASK0, 32'h0000_0000, 4'h1);
		rc("mask0_byte", `IMPTU_ADDR_MASK0, 32'h0000_FF00);
		@(posedge clk);
		{mwr, midx, mval} <= {1'b1, 6'd3, 1'b1};
		@(posedge clk);
		mwr <= 1'b0;
		rc("mask0_src", `IMPTU_ADDR_MASK0, 32'h0000_FF08);
		chk("mask_out_lo", 32'h0000_FF08, {16'h0000, mask[15:0]});
		wr(`IMPTU_ADDR_MASK2, 32'h0000_0000, 4'h3);
		rc("mask2_top", `IMPTU_ADDR_MASK2, 32'h0000_F800);
		chk("mask_out_hi", 32'h0000_0000, {21'h00_0000, mask[42:32]});
		for (int i = 0; i < 4; i++)
		begin
			wr(`IMPTU_ADDR_WDT, i << 5, 4'h1);
			chk("wdt_mode", i, wdm);
		end
		mreq(6'd0, 3'd3);
		chk("acks_blocked", 32'd0, acks);
		pulse(5'h02);
		chk("psw_on", 32'h0000_0000, program_status_word);
		mreq(6'd3, 3'd2);
		chk("acks_masked", 32'd0, acks);
		mreq(6'd0, 3'd3);
		chk("acks", 32'd1, acks);
		chk("isl_ack", 32'h0000_0008, isl);
		chk("psw_ack", 32'h0000_0020, program_status_word);
		pulse(5'h04);
		chk("psw_load", 32'h0000_0000, program_status_word);
		mreq(6'd1, 3'd1);
		chk("isl_nest", 32'h0000_000A, isl);
		rpsw <= 32'h0000_0000;
		pulse(5'h08);
		chk("isl_return_from_intr_instruction", 32'h0000_0008, isl);
		chk("psw_return_from_intr_instruction", 32'h0000_0000, program_status_word);
		pulse(5'h01);
		chk("psw_off", 32'h0000_0020, program_status_word);
		{sdata, rpsw} <= {32'h0000_0080, 32'h0000_0020};
		pulse(5'h04);
		pulse(5'h08);
		chk("isl_np_return_from_intr_instruction", 32'h0000_0008, isl);
		chk("psw_np_return_from_intr_instruction", 32'h0000_0020, program_status_word);
		{tvec, tpc} <= {5'h12, 32'h0000_1234};
		pulse(5'h10);
		chk("trap_load", 32'h0000_0001, pcl);
		chk("trap_pc", 32'h0000_0050, pcv);
		chk("trap_psw", 32'h0000_0060, program_status_word);
		rc("exc_pc", `IMPTU_ADDR_EXC_PC, 32'h0000_1234);
		rc("exc_psw", `IMPTU_ADDR_EXC_PSW, 32'h0000_0020);
		rd(`IMPTU_ADDR_EXC_CAUSE);
		chk("cause", 32'h0000_0052, {16'h0000, d[15:0]});
		{tvec, tpc} <= {5'h0F, 32'h0000_2000};
		pulse(5'h10);
		chk("trap_pc_low", 32'h0000_0040, pcv);
		pulse(5'h08);
		chk("ret_pc", 32'h0000_2000, pcv);
		chk("ret_psw", 32'h0000_0060, program_status_word);
		chk("ret_isl", 32'h0000_0008, isl);
		summarize();
	end
endmodule // imptu_tb_top
`default_nettype wire
